// >>> pdms_pkg.sv
// Constants, register map and types for the powered-device mode block.
// Assumes a 100 MHz reference clock and a 1 us internal timebase tick.
package pdms_pkg;

	// ****************************************
	// Clock and timebase
	// ****************************************
	localparam int CLK_HZ    = 100_000_000;
	localparam int TICK_NS   = 1000;
	localparam int TICK_CYC  = CLK_HZ / (1_000_000_000 / TICK_NS);

	// ****************************************
	// Timing, each in its own unit, then ticks
	// ****************************************
	localparam int ALERT_LOW_MS      = 2;
	localparam int ALERT_LOW_TICKS   = ALERT_LOW_MS * 1_000_000 / TICK_NS;
	localparam int ALERT_PERIOD_MS   = 64;
	localparam int ALERT_PER_TICKS   = ALERT_PERIOD_MS * 1_000_000 / TICK_NS;
	localparam int LAMP_HZ           = 250;
	localparam int LAMP_PER_TICKS    = 1_000_000_000 / TICK_NS / LAMP_HZ;
	localparam int LAMP_DUTY_PCT     = 25;
	localparam int LAMP_HIGH_TICKS   = LAMP_PER_TICKS * LAMP_DUTY_PCT / 100;
	localparam int SLEEP_HOLD_S      = 6;
	localparam int SLEEP_HOLD_TICKS  = SLEEP_HOLD_S * (1_000_000_000 / TICK_NS);
	localparam int START_US          = 256;
	localparam int START_TICKS       = START_US * 1000 / TICK_NS;
	localparam int START_DUTY_PCT    = 25;
	localparam int SLOT_TICKS        = START_TICKS * 100 / START_DUTY_PCT;
	localparam int PATTERN_SLOTS     = 16;
	localparam int ACK_US            = 256;
	localparam int ACK_TICKS         = ACK_US * 1000 / TICK_NS;
	localparam int FRAME_GAP_US      = 1000;
	localparam int FRAME_GAP_TICKS   = FRAME_GAP_US * 1000 / TICK_NS;
	localparam int LIM_LEVELS        = 8;
	localparam logic [3:0] LIM_CURRENT_CODE = 4'h1;

	// ****************************************
	// Pin sampling
	// ****************************************
	localparam int          SYNC_W   = 13;
	localparam logic [12:0] SYNC_RST = 13'h00F0;

	// ****************************************
	// Duty select pin settings
	// ****************************************
	localparam logic [1:0] SDS_FLOAT = 2'h0;
	localparam logic [1:0] SDS_332K  = 2'h1;

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_STATUS   = 4'h4;
	localparam logic [3:0]  REG_LIMIT    = 4'h8;
	localparam int          CTRL_EN_BIT  = 3;
	localparam logic [2:0]  CTRL_CODE_RST = 3'h0;
	localparam logic        CTRL_EN_RST  = 1'b1;
	localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

	typedef enum logic [1:0] {MD_DET, MD_CLS, MD_MARK, MD_PWR} pdms_mode_t;
	typedef enum logic [1:0] {SL_AWAKE, SL_NORMAL, SL_DEEP} pdms_sleep_t;

endpackage

// >>> pdms_ctrl.sv
// Mode, sleep and indicator control of a powered device on a power link.
// Assumes comparator and pin levels arrive asynchronously; Avalon-MM slave.
//
// Operation
// - Indicator patterns only after switch on, power good
// - Indicator disabled in either sleep mode
// - Acknowledge pulse per valid limit request frame
// - Limiting: indicator low 2 ms every 64 ms
// - Sleep lamp 250 Hz, 25 percent, while asleep
// - Edge variant sleeps on request falling edge
// - Held variant needs 6 s low request
// - Wake falling edge returns to normal operation
// - Deep select low gives deep sleep, signature kept
// - Requested limit level replaces classification limit
// - Floating request power limit; low or a single pulse current
// - Floating loop node disables power limiting
// - Duty select four settings; two disable autoclass
// - Four modes chosen from input voltage
// - Detection mode between 1.4 V and 10.1 V
// - Classification mode between 12.5 V and 20.5 V
// - Power mode above power-on threshold
// - At limit, limit control output sinks compensation
// - Power-good sink on while switching and sleeping
// - Start pulse 256 us, then double/triple widths
`timescale 1ns/10ps
module pdms_ctrl #(
	parameter bit EDGE_SLEEP  = 1'b0,
	parameter bit HAS_LAMP    = 1'b1,
	parameter int TICK_CYC    = pdms_pkg::TICK_CYC,
	parameter int ALERT_LOW   = pdms_pkg::ALERT_LOW_TICKS,
	parameter int ALERT_PER   = pdms_pkg::ALERT_PER_TICKS,
	parameter int LAMP_PER    = pdms_pkg::LAMP_PER_TICKS,
	parameter int LAMP_HIGH   = pdms_pkg::LAMP_HIGH_TICKS,
	parameter int HOLD_TICKS  = pdms_pkg::SLEEP_HOLD_TICKS,
	parameter int START_T     = pdms_pkg::START_TICKS,
	parameter int SLOT_T      = pdms_pkg::SLOT_TICKS,
	parameter int ACK_T       = pdms_pkg::ACK_TICKS,
	parameter int GAP_T       = pdms_pkg::FRAME_GAP_TICKS
) (
	input  wire logic                 ref_clk,
	input  wire logic                 resetn,
	input  wire logic [3:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [3:0]           avs_byteenable,
	input  wire logic [31:0]          avs_writedata,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	input  wire logic                 vin_det_cmp,
	input  wire logic                 vin_cls_cmp,
	input  wire logic                 vin_on_cmp,
	input  wire logic                 switch_full_on,
	input  wire logic                 limit_reached,
	input  wire logic                 sleep_request_n,
	input  wire logic                 wake_request_n,
	input  wire logic                 deep_sleep_select_n,
	input  wire logic                 limit_request_in,
	input  wire logic                 limit_request_float,
	input  wire logic                 loop_response_node_float,
	input  wire logic [1:0]           signature_duty_select,
	input  wire logic [3:0]           class_limit_level,
	output pdms_pkg::pdms_mode_t      op_mode,
	output pdms_pkg::pdms_sleep_t     sleep_state,
	output logic                      event_indicator_out_oe_n,
	output logic                      power_good_out_oe_n,
	output logic                      sleep_lamp_out,
	output logic                      limit_control_out,
	output logic                      current_limit_mode,
	output logic [3:0]                limit_level,
	output logic                      maintain_signature_current,
	output logic [1:0]                signature_duty_setting,
	output logic                      autoclass_enable
);
	import pdms_pkg::*;

	function automatic logic at_end(input logic [23:0] cnt, input int lim);
		return cnt == 24'(lim - 1);
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] sync_reg;
	wire  [SYNC_W-1:0] pins = {vin_det_cmp, vin_cls_cmp, vin_on_cmp,
		switch_full_on, limit_reached, sleep_request_n, wake_request_n,
		deep_sleep_select_n, limit_request_in, limit_request_float,
		loop_response_node_float, signature_duty_select};

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			meta_reg <= SYNC_RST;
			sync_reg <= SYNC_RST;
		end else begin
			meta_reg <= pins;
			sync_reg <= meta_reg;
		end
	end

	wire       det_s   = sync_reg[12];
	wire       cls_s   = sync_reg[11];
	wire       on_s    = sync_reg[10];
	wire       sw_s    = sync_reg[9];
	wire       lr_s    = sync_reg[8];
	wire       sl_s    = sync_reg[7];
	wire       wk_s    = sync_reg[6];
	wire       deep_s  = sync_reg[5];
	wire       lim_s   = sync_reg[4];
	wire       lfl_s   = sync_reg[3];
	wire       loop_s  = sync_reg[2];
	wire [1:0] sds_s   = sync_reg[1:0];

	// ****************************************
	// Shared timebase, cleared at reset
	// ****************************************
	logic [15:0] tick_cnt_reg;
	logic        tick_reg;
	wire         tick_wrap = tick_cnt_reg == 16'(TICK_CYC - 1);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_wrap ? 16'h0000 : tick_cnt_reg + 16'h0001;
			tick_reg     <= tick_wrap;
		end
	end

	// ****************************************
	// Operating mode
	// ****************************************
	pdms_mode_t  mode_reg;
	pdms_mode_t  mode_next;
	pdms_sleep_t sleep_reg;
	pdms_sleep_t sleep_next;

	always_comb begin
		if (on_s)
			mode_next = MD_PWR;
		else if (cls_s)
			mode_next = MD_CLS;
		else if (det_s)
			mode_next = MD_DET;
		else if (mode_reg == MD_CLS || mode_reg == MD_MARK)
			mode_next = MD_MARK;
		else
			mode_next = MD_DET;
	end

	wire pwr_ready = mode_reg == MD_PWR && sw_s;
	wire awake     = sleep_reg == SL_AWAKE;
	wire pg_ok     = pwr_ready && awake;

	// ****************************************
	// Sleep entry and wake
	// ****************************************
	logic        sl_prev_reg;
	logic        wk_prev_reg;
	logic        hold_run_reg;
	logic [23:0] hold_cnt_reg;
	wire         sl_fall   = sl_prev_reg && !sl_s;
	wire         wk_fall   = wk_prev_reg && !wk_s;
	wire         held_done = hold_run_reg && !sl_s && tick_reg &&
		at_end(hold_cnt_reg, HOLD_TICKS);
	wire         sleep_req = EDGE_SLEEP ? sl_fall : held_done;
	wire         sleep_entry = sleep_req && pwr_ready && awake;

	always_comb begin
		sleep_next = sleep_reg;
		if (mode_reg != MD_PWR) begin
			sleep_next = SL_AWAKE;
		end else begin
			case (sleep_reg)
				SL_AWAKE: begin
					if (sleep_entry)
						sleep_next = deep_s ? SL_NORMAL : SL_DEEP;
				end
				SL_NORMAL, SL_DEEP: begin
					if (wk_fall)
						sleep_next = SL_AWAKE;
				end
				default: sleep_next = SL_AWAKE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			mode_reg     <= MD_DET;
			sleep_reg    <= SL_AWAKE;
			sl_prev_reg  <= 1'b1;
			wk_prev_reg  <= 1'b1;
			hold_run_reg <= 1'b0;
			hold_cnt_reg <= 24'h00_0000;
		end else begin
			mode_reg     <= mode_next;
			sleep_reg    <= sleep_next;
			sl_prev_reg  <= sl_s;
			wk_prev_reg  <= wk_s;
			// A brief low drops the run flag, so the pulse is ignored
			hold_run_reg <= (hold_run_reg || sl_fall) && !sl_s && !held_done;
			if (!hold_run_reg || sl_s)
				hold_cnt_reg <= 24'h00_0000;
			else if (tick_reg)
				hold_cnt_reg <= hold_cnt_reg + 24'h00_0001;
		end
	end

	// ****************************************
	// Limit request frames
	// ****************************************
	logic        lim_prev_reg;
	logic [23:0] gap_cnt_reg;
	logic [3:0]  pulse_cnt_reg;
	logic [3:0]  req_level_reg;
	logic        req_valid_reg;
	logic        req_current_reg;
	logic        shorted_reg;
	wire         lim_edge  = lim_prev_reg != lim_s;
	wire         lim_fall  = lim_prev_reg && !lim_s;
	wire         gap_hit   = tick_reg && at_end(gap_cnt_reg, GAP_T);
	wire         frame_end = gap_hit && lim_s && pulse_cnt_reg != 4'h0;
	wire         ack_go    = frame_end &&
		pulse_cnt_reg <= 4'(LIM_LEVELS);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			lim_prev_reg    <= 1'b1;
			gap_cnt_reg     <= 24'h00_0000;
			pulse_cnt_reg   <= 4'h0;
			req_level_reg   <= 4'h0;
			req_valid_reg   <= 1'b0;
			req_current_reg <= 1'b0;
			shorted_reg     <= 1'b0;
		end else begin
			lim_prev_reg <= lim_s;
			if (lim_edge)
				gap_cnt_reg <= 24'h00_0000;
			else if (tick_reg && gap_cnt_reg != 24'(GAP_T))
				gap_cnt_reg <= gap_cnt_reg + 24'h00_0001;
			if (gap_hit)
				pulse_cnt_reg <= 4'h0;
			else if (lim_fall && pulse_cnt_reg != 4'hF)
				pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
			if (ack_go) begin
				req_level_reg   <= pulse_cnt_reg;
				req_valid_reg   <= 1'b1;
				req_current_reg <= pulse_cnt_reg == LIM_CURRENT_CODE;
			end
			if (lim_edge)
				shorted_reg <= 1'b0;
			else if (gap_hit && !lim_s)
				shorted_reg <= 1'b1;
		end
	end

	// ****************************************
	// Limit control
	// ****************************************
	wire cur_mode_next = !lfl_s && (shorted_reg || req_current_reg);
	// Current limiting survives a floating loop node; power limiting does not
	wire lim_ctl_next  = lr_s && (current_limit_mode || !loop_s);
	wire [3:0] level_next = req_valid_reg ? req_level_reg
		: class_limit_level;

	// ****************************************
	// Indicator: acknowledge, alert, pattern
	// ****************************************
	logic [23:0] ack_cnt_reg;
	logic [23:0] alert_cnt_reg;
	logic [23:0] pat_off_reg;
	logic [4:0]  pat_slot_reg;
	logic [2:0]  ctrl_code_reg;
	logic        ctrl_en_reg;
	wire         slot_end  = tick_reg && at_end(pat_off_reg, SLOT_T);
	wire [23:0]  wide_t    = 24'(START_T * 3);
	wire [23:0]  dbl_t     = 24'(START_T * 2);
	wire         bit_sel   = pat_slot_reg >= 5'h01 && pat_slot_reg <= 5'h03 &&
		ctrl_code_reg[2'(pat_slot_reg - 5'h01)];
	wire [23:0]  pulse_len = pat_slot_reg == 5'h00 ? 24'(START_T)
		: (bit_sel ? wide_t : dbl_t);
	wire         pat_low   = ctrl_en_reg && pat_slot_reg <= 5'h03 &&
		pat_off_reg < pulse_len;
	wire         alert_low = limit_control_out &&
		alert_cnt_reg < 24'(ALERT_LOW);
	wire         ack_low   = ack_cnt_reg != 24'h00_0000;
	// Sleep and an unfinished start-up both silence every source
	wire         ind_low   = pg_ok &&
		(ack_low || alert_low || pat_low);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ack_cnt_reg   <= 24'h00_0000;
			alert_cnt_reg <= 24'h00_0000;
			pat_off_reg   <= 24'h00_0000;
			pat_slot_reg  <= 5'h00;
		end else begin
			if (ack_go)
				ack_cnt_reg <= 24'(ACK_T);
			else if (tick_reg && ack_low)
				ack_cnt_reg <= ack_cnt_reg - 24'h00_0001;
			if (!limit_control_out || (tick_reg &&
					at_end(alert_cnt_reg, ALERT_PER)))
				alert_cnt_reg <= 24'h00_0000;
			else if (tick_reg)
				alert_cnt_reg <= alert_cnt_reg + 24'h00_0001;
			if (!pg_ok || slot_end)
				pat_off_reg <= 24'h00_0000;
			else if (tick_reg)
				pat_off_reg <= pat_off_reg + 24'h00_0001;
			if (!pg_ok)
				pat_slot_reg <= 5'h00;
			else if (slot_end)
				pat_slot_reg <= pat_slot_reg == 5'(PATTERN_SLOTS - 1) ? 5'h00
					: pat_slot_reg + 5'h01;
		end
	end

	// ****************************************
	// Sleep lamp
	// ****************************************
	logic [23:0] lamp_cnt_reg;
	wire         lamp_next = HAS_LAMP && !awake &&
		lamp_cnt_reg < 24'(LAMP_HIGH);

	always_ff @(posedge ref_clk) begin
		if (!resetn)
			lamp_cnt_reg <= 24'h00_0000;
		else if (awake || (tick_reg && at_end(lamp_cnt_reg, LAMP_PER)))
			lamp_cnt_reg <= 24'h00_0000;
		else if (tick_reg)
			lamp_cnt_reg <= lamp_cnt_reg + 24'h00_0001;
	end

	// ****************************************
	// Register bus, one wait state per access
	// ****************************************
	logic        wait_reg;
	logic [31:0] rdata_reg;
	wire         bus_req = avs_read || avs_write;
	wire         wr_go   = avs_write && !wait_reg && avs_byteenable[0] &&
		avs_address == REG_CTRL;
	wire [31:0]  status_word = {24'h00_0000, autoclass_enable,
		limit_control_out, current_limit_mode, pg_ok, sleep_reg, mode_reg};
	wire [31:0]  rd_mux = avs_address == REG_CTRL ?
			{28'h000_0000, ctrl_en_reg, ctrl_code_reg}
		: avs_address == REG_STATUS ? status_word
		: avs_address == REG_LIMIT ?
			{27'h000_0000, req_valid_reg, limit_level}
		: RD_UNMAPPED;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wait_reg      <= 1'b1;
			rdata_reg     <= 32'h0000_0000;
			ctrl_code_reg <= CTRL_CODE_RST;
			ctrl_en_reg   <= CTRL_EN_RST;
		end else begin
			wait_reg <= !(bus_req && wait_reg);
			if (bus_req && wait_reg)
				rdata_reg <= rd_mux;
			if (wr_go) begin
				ctrl_code_reg <= avs_writedata[2:0];
				ctrl_en_reg   <= avs_writedata[CTRL_EN_BIT];
			end
		end
	end

	// ****************************************
	// Output flops
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			event_indicator_out_oe_n   <= 1'b1;
			power_good_out_oe_n        <= 1'b1;
			sleep_lamp_out             <= 1'b0;
			limit_control_out          <= 1'b0;
			current_limit_mode         <= 1'b0;
			limit_level                <= 4'h0;
			maintain_signature_current <= 1'b0;
			signature_duty_setting     <= SDS_FLOAT;
			autoclass_enable           <= 1'b0;
		end else begin
			event_indicator_out_oe_n   <= !ind_low;
			power_good_out_oe_n        <= !(mode_reg == MD_PWR &&
				(!sw_s || !awake));
			sleep_lamp_out             <= lamp_next;
			limit_control_out          <= lim_ctl_next;
			current_limit_mode         <= cur_mode_next;
			limit_level                <= level_next;
			maintain_signature_current <= mode_reg == MD_PWR;
			signature_duty_setting     <= sds_s;
			autoclass_enable           <= sds_s != SDS_FLOAT &&
				sds_s != SDS_332K;
		end
	end

	assign op_mode         = mode_reg;
	assign sleep_state     = sleep_reg;
	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_wake;
		!awake ##0 wk_fall;
	endsequence
	sequence s_deep_entry;
		sleep_entry && !deep_s && on_s;
	endsequence

	property p_ind_gate;
		!pg_ok |=> event_indicator_out_oe_n;
	endproperty
	a_ind_gate: assert property (p_ind_gate)
		else $error("indicator active before power good");
	property p_ind_sleep;
		sleep_reg != SL_AWAKE |=> event_indicator_out_oe_n;
	endproperty
	a_ind_sleep: assert property (p_ind_sleep)
		else $error("indicator active during sleep");
	property p_ack;
		ack_go && pg_ok ##1 pg_ok |=> !event_indicator_out_oe_n;
	endproperty
	a_ack: assert property (p_ack)
		else $error("acknowledge pulse missing");
	property p_alert;
		$rose(limit_control_out) && pg_ok |=> !event_indicator_out_oe_n;
	endproperty
	a_alert: assert property (p_alert)
		else $error("limit alert did not start");
	property p_lamp_off;
		awake |=> !sleep_lamp_out;
	endproperty
	a_lamp_off: assert property (p_lamp_off)
		else $error("sleep lamp lit while awake");
	property p_edge_entry;
		EDGE_SLEEP && sleep_entry && on_s |=> sleep_reg != SL_AWAKE;
	endproperty
	a_edge_entry: assert property (p_edge_entry)
		else $error("edge sleep request not taken");
	property p_hold;
		!EDGE_SLEEP && $fell(awake) |->
			$past(hold_cnt_reg) == 24'(HOLD_TICKS - 1);
	endproperty
	a_hold: assert property (p_hold)
		else $error("sleep entered before hold time");
	property p_wake;
		s_wake |=> awake;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake edge did not wake");
	property p_deep;
		s_deep_entry |=> sleep_reg == SL_DEEP ##1 maintain_signature_current;
	endproperty
	a_deep: assert property (p_deep)
		else $error("deep sleep or signature current missing");
	property p_loop;
		loop_s && !current_limit_mode |=> !limit_control_out;
	endproperty
	a_loop: assert property (p_loop)
		else $error("power limiting with floating loop node");
	property p_mode_pwr;
		on_s |=> op_mode == MD_PWR;
	endproperty
	a_mode_pwr: assert property (p_mode_pwr)
		else $error("power mode not entered");
	property p_pg_sink;
		op_mode == MD_DET || op_mode == MD_CLS |=> power_good_out_oe_n;
	endproperty
	a_pg_sink: assert property (p_pg_sink)
		else $error("power-good sink on outside power mode");

endmodule

// >>> pdms_far_side.sv
// Far-side model: supply stages and limit request frames.
// Assumes the bench sets a 2-cycle tick on the block.
`timescale 1ns/10ps
module pdms_far_side (
	input  wire logic       ref_clk,
	input  wire logic [1:0] stage,
	output logic            vin_det_cmp,
	output logic            vin_cls_cmp,
	output logic            vin_on_cmp,
	output logic            switch_full_on,
	output logic            limit_request_in
);
	int on_cnt;
	// ****************************************
	// Supply: 1 detect, 2 classify, 3 power
	// ****************************************
	assign vin_det_cmp = (stage == 2'h1);
	assign vin_cls_cmp = (stage == 2'h2);
	assign vin_on_cmp  = (stage == 2'h3);
	initial begin
		on_cnt = 0;
		switch_full_on = 1'b0;
		limit_request_in = 1'b1;
	end
	// Switch lags power mode, as inrush would
	always @(posedge ref_clk) begin
		on_cnt <= vin_on_cmp ? on_cnt + 1 : 0;
		switch_full_on <= (on_cnt > 10);
	end
	// Pulses 2 ticks low, 2 high; gap ends frame
	task automatic send_frame(input int n);
		repeat (n) begin
			limit_request_in <= 1'b0;
			repeat (4) @(posedge ref_clk);
			limit_request_in <= 1'b1;
			repeat (4) @(posedge ref_clk);
		end
	endtask
endmodule

// >>> testbench.sv
// Bench for the mode and indicator block, with short tick counts.
// Assumes the far-side model drives supply and limit request pins.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	fails++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module testbench;
	import pdms_pkg::*;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [3:0]  class_limit_level = 4'h5;
	pdms_sleep_t edge_state;
	logic [31:0] avs_readdata, rd;
	logic        avs_waitrequest;
	logic [1:0]  stage = 2'h0;
	logic [1:0]  signature_duty_select = 2'h0;
	logic        limit_reached = 1'b0;
	logic        sleep_request_n = 1'b1;
	logic        wake_request_n = 1'b1;
	logic        deep_sleep_select_n = 1'b1;
	logic        limit_request_float = 1'b0;
	logic        loop_response_node_float = 1'b0;
	logic        vin_det_cmp, vin_cls_cmp, vin_on_cmp, switch_full_on;
	logic        limit_request_in, event_indicator_out_oe_n;
	logic        power_good_out_oe_n, sleep_lamp_out, limit_control_out;
	logic        current_limit_mode, maintain_signature_current;
	logic        autoclass_enable;
	logic [3:0]  limit_level;
	logic [1:0]  signature_duty_setting;
	pdms_mode_t  op_mode;
	pdms_sleep_t sleep_state;
	int          fails = 0;
	int          checks = 0;
	int          lo, hi;
	always #5 ref_clk = ~ref_clk;
	// Short tick counts keep the run brief
	localparam int TB_CYC = 2, TB_ALOW = 4, TB_APER = 16, TB_LPER = 8,
		TB_LHIGH = 2, TB_HOLD = 20, TB_START = 2, TB_SLOT = 8,
		TB_ACK = 2, TB_GAP = 6;
	localparam bit TB_EDGE = 1'b1;
	pdms_ctrl #(.TICK_CYC(TB_CYC), .ALERT_LOW(TB_ALOW),
		.ALERT_PER(TB_APER), .LAMP_PER(TB_LPER), .LAMP_HIGH(TB_LHIGH),
		.HOLD_TICKS(TB_HOLD), .START_T(TB_START), .SLOT_T(TB_SLOT),
		.ACK_T(TB_ACK), .GAP_T(TB_GAP)) uut (.ref_clk, .resetn,
		.avs_address, .avs_read, .avs_write, .avs_byteenable,
		.avs_writedata,
		.avs_readdata, .avs_waitrequest, .vin_det_cmp, .vin_cls_cmp,
		.vin_on_cmp, .switch_full_on, .limit_reached, .sleep_request_n,
		.wake_request_n, .deep_sleep_select_n, .limit_request_in,
		.limit_request_float, .loop_response_node_float,
		.signature_duty_select, .class_limit_level, .op_mode,
		.sleep_state, .event_indicator_out_oe_n, .power_good_out_oe_n,
		.sleep_lamp_out, .limit_control_out, .current_limit_mode,
		.limit_level, .maintain_signature_current,
		.signature_duty_setting, .autoclass_enable);
	// Edge variant on the same pins; only its sleep state is watched
	pdms_ctrl #(.EDGE_SLEEP(TB_EDGE), .TICK_CYC(TB_CYC),
		.ALERT_LOW(TB_ALOW), .ALERT_PER(TB_APER), .LAMP_PER(TB_LPER),
		.LAMP_HIGH(TB_LHIGH), .HOLD_TICKS(TB_HOLD), .START_T(TB_START),
		.SLOT_T(TB_SLOT), .ACK_T(TB_ACK), .GAP_T(TB_GAP)) uut_edge (
		.ref_clk, .resetn, .avs_address, .avs_read, .avs_write,
		.avs_byteenable, .avs_writedata, .avs_readdata(),
		.avs_waitrequest(), .vin_det_cmp, .vin_cls_cmp, .vin_on_cmp,
		.switch_full_on, .limit_reached, .sleep_request_n,
		.wake_request_n, .deep_sleep_select_n, .limit_request_in,
		.limit_request_float, .loop_response_node_float,
		.signature_duty_select, .class_limit_level, .op_mode(),
		.sleep_state(edge_state), .event_indicator_out_oe_n(),
		.power_good_out_oe_n(), .sleep_lamp_out(),
		.limit_control_out(), .current_limit_mode(), .limit_level(),
		.maintain_signature_current(), .signature_duty_setting(),
		.autoclass_enable());
	pdms_far_side far (.ref_clk, .stage, .vin_det_cmp, .vin_cls_cmp,
		.vin_on_cmp, .switch_full_on, .limit_request_in);
	// ****************************************
	// Tasks
	// ****************************************
	task automatic print_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Bounded wait: a stuck slave must not hang the run
	task automatic bus(input bit wr, input logic [3:0] a,
		input logic [31:0] d);
		int k;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		for (k = 0; k < 20; k++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (k == 20)
			`CHK("waitrequest", 1'b0, 1'b1)
		if (k == 20)
			print_verdict();
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic count(input int n);
		lo = 0;
		hi = 0;
		repeat (n) begin
			@(posedge ref_clk);
			lo += (event_indicator_out_oe_n === 1'b0);
			hi += (sleep_lamp_out === 1'b1);
		end
	endtask
	task automatic pin(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wake();
		sleep_request_n <= 1'b1;
		wake_request_n <= 1'b0;
		pin(10);
		wake_request_n <= 1'b1;
		`CHK("awake", SL_AWAKE, sleep_state)
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		pin(8);
		resetn <= 1'b1;
		pin(1);
		bus(0, REG_CTRL, 0);
		`CHK("ctrl", {28'h0, CTRL_EN_RST, CTRL_CODE_RST}, rd[31:0])
		bus(0, 4'hC, 32'hFFFF_FFFF);
		`CHK("unmapped", RD_UNMAPPED, rd)
		avs_byteenable <= 4'hE;
		bus(1, REG_CTRL, 32'h0000_0007);
		avs_byteenable <= 4'hF;
		bus(0, REG_CTRL, 0);
		`CHK("masked", {28'h0, CTRL_EN_RST, CTRL_CODE_RST}, rd)
		stage <= 2'h1;
		pin(6);
		`CHK("det", MD_DET, op_mode)
		stage <= 2'h2;
		pin(6);
		`CHK("cls", MD_CLS, op_mode)
		stage <= 2'h0;
		pin(6);
		`CHK("mark", MD_MARK, op_mode)
		stage <= 2'h3;
		count(6);
		`CHK("pwr", MD_PWR, op_mode)
		`CHK("pg sink", 1'b0, power_good_out_oe_n)
		`CHK("early pattern", 0, lo)
		pin(20);
		`CHK("pg free", 1'b1, power_good_out_oe_n)
		count(256);
		`CHK("pattern low", 28, lo)
		bus(1, REG_CTRL, 32'h0000_000F);
		bus(0, REG_CTRL, 0);
		`CHK("ctrl wr", 32'h0000_000F, rd)
		count(256);
		`CHK("pattern wide", 40, lo)
		bus(1, REG_CTRL, 0);
		$display("modes and pattern done");
		`CHK("class level", 4'h5, limit_level)
		far.send_frame(2);
		count(30);
		`CHK("ack", 4, lo)
		`CHK("level", 4'h2, limit_level)
		`CHK("power mode", 1'b0, current_limit_mode)
		bus(0, REG_LIMIT, 0);
		`CHK("limit reg", 32'h0000_0012, rd)
		far.send_frame(1);
		pin(30);
		`CHK("cur mode", 1'b1, current_limit_mode)
		limit_reached <= 1'b1;
		pin(10);
		`CHK("limit ctl", 1'b1, limit_control_out)
		count(64);
		`CHK("alert low", 16, lo)
		limit_request_float <= 1'b1;
		loop_response_node_float <= 1'b1;
		pin(10);
		`CHK("float mode", 1'b0, current_limit_mode)
		`CHK("loop float", 1'b0, limit_control_out)
		limit_reached <= 1'b0;
		$display("limit tests done");
		sleep_request_n <= 1'b0;
		pin(10);
		sleep_request_n <= 1'b1;
		pin(60);
		`CHK("short", SL_AWAKE, sleep_state)
		`CHK("edge sleep", SL_NORMAL, edge_state)
		sleep_request_n <= 1'b0;
		pin(60);
		`CHK("sleep", SL_NORMAL, sleep_state)
		count(32);
		`CHK("lamp", 8, hi)
		`CHK("ind off", 0, lo)
		`CHK("pg sleep", 1'b0, power_good_out_oe_n)
		wake();
		deep_sleep_select_n <= 1'b0;
		sleep_request_n <= 1'b0;
		pin(60);
		`CHK("deep", SL_DEEP, sleep_state)
		`CHK("mps", 1'b1, maintain_signature_current)
		wake();
		stage <= 2'h1;
		pin(8);
		`CHK("det again", MD_DET, op_mode)
		`CHK("mps off", 1'b0, maintain_signature_current)
		sleep_request_n <= 1'b0;
		pin(60);
		`CHK("det sleep", SL_AWAKE, sleep_state)
		sleep_request_n <= 1'b1;
		$display("sleep tests done");
		for (int n = 0; n < 4; n++) begin
			signature_duty_select <= n[1:0];
			pin(6);
			`CHK("duty", n[1:0], signature_duty_setting)
			`CHK("autoclass", n >= 2, autoclass_enable)
		end
		bus(0, REG_STATUS, 0);
		`CHK("status", 32'h0000_0080, rd)
		$display("duty tests done");
		print_verdict();
	end
	initial begin
		pin(20000);
		`CHK("timeout", 1'b0, 1'b1)
		print_verdict();
	end
endmodule
